/* File: pkg/uart_sb_pkg.sv */
// Purpose: Shared constants for the serial transceiver sideband block.
// Assumes: 32-bit register port with byte addresses, one component clock.
// Notes: Offsets are byte addresses of aligned words.
package uart_sb_pkg;

  // Register map.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_DATA = 8'h04;
  localparam logic [7:0] REG_RX_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR = 8'h18;

  // Control register fields and reset value.
  localparam int CTRL_FLOW_BIT = 0;
  localparam logic CTRL_FLOW_RESET = 1'b0;

  // Interrupt status layout, shared by enable and clear registers.
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_CHAR = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_FRAME = 2;
  localparam int IRQ_TX_DONE = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;

  // Status register field positions.
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_TX_PEND = 8;
  localparam int STAT_TX_BUSY = 9;
  localparam int STAT_RTS_N = 10;

  // Character frame: start, eight data bits, one stop bit.
  localparam int DATA_BITS = 8;
  localparam logic [3:0] BIT_START = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h8;
  localparam logic [3:0] BIT_STOP = 4'h9;

  // Documented defaults.
  localparam int OVS_DEFAULT = 8;
  localparam int RX_DEPTH_DEFAULT = 4;

endpackage

/* File: tb/uart_sb_remote.sv */
// Purpose: Behavioural far-side serial device for the sideband block.
// Assumes: Shares the component clock; one bit spans OVS cycles.
// Notes: Sends queued bytes on o_rx and decodes bytes seen on i_tx.
`timescale 1ns/100ps
module uart_sb_remote #(
  parameter int OVS = 8
) (
  // Clock.
  input wire logic i_sys_clk,
  // Serial link and flow control.
  input wire logic i_tx,
  input wire logic i_rts_n,
  output logic o_rx
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [9:0] frame;
  logic [7:0] shift;

  ////////////////////////////////////////////////////////////////
  // A new character starts only while request-to-send is active.
  initial begin
    o_rx = 1'b1;
    forever begin
      @(posedge i_sys_clk);
      if (send_q.size() != 0 && i_rts_n === 1'b0) begin
        frame = {1'b1, send_q.pop_front(), 1'b0};
        for (int k = 0; k < 10; k++) begin
          o_rx <= frame[k];
          repeat (OVS) @(posedge i_sys_clk);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sampling on the falling edge keeps clear of the registered line.
  initial begin
    forever begin
      @(negedge i_sys_clk);
      if (i_tx === 1'b0) begin
        repeat (OVS / 2) @(negedge i_sys_clk);
        for (int k = 0; k < 8; k++) begin
          repeat (OVS) @(negedge i_sys_clk);
          shift[k] = i_tx;
        end
        got_q.push_back(shift);
        repeat (OVS) @(negedge i_sys_clk);
      end
    end
  end
endmodule

/* File: tb/uart_sb_top_test.sv */
// Purpose: Self-checking bench for the sideband block.
// Assumes: OVS of 8, receive store of 4, component clock at 25 MHz.
// Notes: Line monitors run on the falling edge where outputs are settled.
`timescale 1ns/100ps
module uart_sb_top_test import uart_sb_pkg::*;;
  localparam int OVS = 8;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cts_n = 1'b1;
  logic i_rx;
  logic [31:0] o_rd_data;
  logic o_tx, o_tx_en, o_rts_n, o_tx_crc_clk, o_tx_crc_data;
  logic o_rx_crc_clk, o_rx_crc_data, o_rx_done, o_irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tx_t0, rx_t0, rx_last, tx_strb, rx_strb;
  logic rx_busy = 1'b0;
  logic tx_d = 1'b1;
  logic rx_d = 1'b1;
  logic en_d = 1'b0;
  logic rts_d = 1'b0;

  uart_sb_top #(.OVS(OVS), .RX_DEPTH(4)) dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_rx(i_rx), .i_cts_n(i_cts_n),
    .o_tx(o_tx), .o_tx_en(o_tx_en), .o_rts_n(o_rts_n), .o_tx_crc_clk(o_tx_crc_clk),
    .o_tx_crc_data(o_tx_crc_data), .o_rx_crc_clk(o_rx_crc_clk), .o_rx_crc_data(o_rx_crc_data),
    .o_rx_done(o_rx_done), .o_irq(o_irq));
  uart_sb_remote #(.OVS(OVS)) remote (.i_sys_clk(i_sys_clk), .i_tx(o_tx), .i_rts_n(o_rts_n), .o_rx(i_rx));

  always #20 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rd_data, exp);
  endtask

  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Strobe phases are measured from the bit start seen on each line.
  always @(negedge i_sys_clk) begin
    if (!i_sys_rst) begin
      chk(o_tx_crc_data, tx_d);
      chk(o_rx_crc_data, rx_d);
      if (o_tx_en && !en_d) tx_t0 = cyc;
      if (o_tx_crc_clk) begin
        tx_strb++;
        chk(32'((cyc - tx_t0) % OVS), 32'(OVS / 2 + 1));
        chk(o_tx_en, 1'b1);
      end
      if (!rx_busy && rx_d && !i_rx) begin
        rx_busy = 1'b1;
        rx_t0 = cyc;
        rx_strb = 0;
      end
      if (o_rx_crc_clk) begin
        rx_strb++;
        rx_last = cyc;
        chk(32'((cyc - rx_t0 - 1) % OVS), 32'(OVS / 2));
        chk(rx_busy, 1'b1);
      end
      if (o_rx_done) begin
        chk(32'(cyc - rx_t0 - 1), 32'(OVS / 2 + 9 * OVS));
        chk(32'(rx_strb), 32'h8);
        rx_busy = 1'b0;
      end
      if (o_rts_n && !rts_d) chk(32'(cyc - rx_last), 32'h1);
    end
    tx_d = o_tx;
    rx_d = i_rx;
    en_d = o_tx_en;
    rts_d = o_rts_n;
  end

  initial begin
    #800000;
    num_errors++;
    $display("watchdog expired");
    summarize();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk({o_tx, o_tx_en, o_rts_n, o_irq, o_tx_crc_data}, 5'h11);
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_IRQ_EN, 32'h0);
    rd_chk(8'h1c, 32'h0);
    $display("test reset done");
    reg_wr(REG_IRQ_EN, 32'h8);
    reg_wr(REG_TX_DATA, 32'ha5);
    repeat (20) @(posedge i_sys_clk);
    #1;
    chk(o_tx_en, 1'b0);
    @(posedge i_sys_clk);
    i_cts_n <= 1'b0;
    tx_strb = 0;
    @(posedge i_sys_clk);
    #1;
    chk({o_tx_en, o_tx}, 2'b01);
    @(posedge i_sys_clk);
    #1;
    chk({o_tx_en, o_tx}, 2'b10);
    @(posedge i_sys_clk);
    i_cts_n <= 1'b1;
    for (int i = 0; i < 200 && remote.got_q.size() == 0; i++) @(posedge i_sys_clk);
    repeat (2 * OVS) @(posedge i_sys_clk);
    #1;
    chk(32'(remote.got_q.size()), 32'h1);
    chk(remote.got_q[0], 8'ha5);
    chk({o_tx_en, o_irq, 4'(tx_strb)}, 6'h18);
    reg_wr(REG_IRQ_CLR, 32'h8);
    rd_chk(REG_IRQ_STAT, 32'h0);
    chk(o_irq, 1'b0);
    $display("test transmit done");
    reg_wr(REG_IRQ_EN, 32'h0);
    remote.send_q.push_back(8'h3c);
    repeat (11 * OVS + 10) @(posedge i_sys_clk);
    rd_chk(REG_IRQ_STAT, 32'h1);
    chk(o_irq, 1'b0);
    reg_wr(REG_IRQ_EN, 32'h1);
    rd_chk(REG_STATUS, 32'h1);
    chk(o_irq, 1'b1);
    reg_wr(REG_IRQ_CLR, 32'h1);
    rd_chk(REG_RX_DATA, 32'h3c);
    chk(o_irq, 1'b0);
    rd_chk(REG_RX_DATA, 32'h0);
    $display("test receive done");
    reg_wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) remote.send_q.push_back(8'(8'h10 + i));
    for (int i = 0; i < 60 * OVS && o_rts_n !== 1'b1; i++) @(posedge i_sys_clk);
    repeat (20 * OVS) @(posedge i_sys_clk);
    chk(32'(remote.send_q.size()), 32'h1);
    rd_chk(REG_STATUS, 32'h404);
    rd_chk(REG_RX_DATA, 32'h10);
    chk(o_rts_n, 1'b0);
    repeat (12 * OVS) @(posedge i_sys_clk);
    for (int i = 0; i < 5; i++) rd_chk(REG_RX_DATA, 32'(i < 4 ? 8'h11 + i : 0));
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_IRQ_STAT, 32'h1);
    $display("test flow control done");
    // With flow control off the fifth character finds the store full and is dropped.
    reg_wr(REG_IRQ_CLR, 32'hf);
    reg_wr(REG_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) remote.send_q.push_back(8'(8'h20 + i));
    repeat (5 * (10 * OVS + 1) + 10) @(posedge i_sys_clk);
    #1;
    chk(o_rts_n, 1'b0);
    rd_chk(REG_IRQ_STAT, 32'h3);
    rd_chk(REG_STATUS, 32'h4);
    for (int i = 0; i < 4; i++) rd_chk(REG_RX_DATA, 32'(8'h20 + i));
    $display("test overrun done");
    summarize();
  end
endmodule

/* File: verilog/uart_sb_rx_mem.sv */
// Purpose: Small receive character store with registered read data.
// Assumes: One write port and one read port on the component clock.
// Notes: A write to the word being read is passed straight to the output.
`timescale 1ns/100ps
module uart_sb_rx_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock.
  input wire logic i_sys_clk,
  // Write port.
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port.
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] store [DEPTH];

  wire bypass = i_we && (i_waddr == i_raddr);

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      store[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_rdata <= bypass ? i_wdata : store[i_raddr];
  end

endmodule

/* File: verilog/uart_sb_top.sv */
// Purpose: Serial transceiver sideband logic: flow control and CRC bit taps.
// Assumes: Pins and register port are synchronous to i_sys_clk.
// Notes: i_sys_clk runs at the bit rate times the oversampling factor.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// How it works
// - Falling clear-to-send raises internal enable promptly.
// - Drive enable registered once more before pin.
// - Start bit leaves with drive enable rising.
// - Transmit strobe rises half bit plus one.
// - Transmit copy lags serial line one cycle.
// - Reset is sampled on the clock edge.
// - Receive strobe rises about mid bit.
// - Receive event follows stop bit sampling by two cycles.
// - Receive copy lags input by one cycle.
// - Full receive store deasserts request-to-send.
// - Character stored cycle after last strobe.
// - Every bit spans oversampling-factor clock cycles.
// - Start edge resets counters; sample fourth clock.
module uart_sb_top
  import uart_sb_pkg::*;
#(
  parameter int OVS = OVS_DEFAULT,
  parameter int RX_DEPTH = RX_DEPTH_DEFAULT
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  // Serial link and flow control.
  input wire logic i_rx,
  input wire logic i_cts_n,
  output logic o_tx,
  output logic o_tx_en,
  output logic o_rts_n,
  // CRC taps and events.
  output logic o_tx_crc_clk,
  output logic o_tx_crc_data,
  output logic o_rx_crc_clk,
  output logic o_rx_crc_data,
  output logic o_rx_done,
  output logic o_irq
);

  if (OVS != 8 && OVS != 16) begin : g_bad_ovs
    $error("OVS must be 8 or 16");
  end
  if (RX_DEPTH < 2 || RX_DEPTH > 128 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("RX_DEPTH must be a power of two from 2 to 128");
  end

  localparam int TICK_W = $clog2(OVS);
  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(OVS - 1);
  localparam logic [TICK_W-1:0] TX_STROBE_TICK = TICK_W'(OVS / 2);
  localparam logic [TICK_W-1:0] RX_SAMPLE_TICK = TICK_W'(OVS / 2 - 2);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(RX_DEPTH);
  localparam int RX_SAMPLE_DLY = OVS / 2 - 1;
  localparam int TX_STROBE_DLY = OVS / 2 + 1;

  typedef enum logic [1:0] {TX_IDLE, TX_ARM, TX_SHIFT} tx_state_type;
  typedef enum logic {RX_IDLE, RX_RECV} rx_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  logic flow_en;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [DATA_BITS-1:0] tx_hold;
  logic tx_pend;
  logic [AW:0] rx_count;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [DATA_BITS-1:0] mem_q;
  tx_state_type tx_state;
  rx_state_type rx_state;

  wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
  wire wr_tx = i_wr && (i_addr == REG_TX_DATA);
  wire wr_en = i_wr && (i_addr == REG_IRQ_EN);
  wire wr_clr = i_wr && (i_addr == REG_IRQ_CLR);
  wire rd_rx = i_rd && (i_addr == REG_RX_DATA);

  wire [31:0] status_word = {21'h000000, o_rts_n, (tx_state != TX_IDLE), tx_pend,
                             {(8 - AW - 1){1'b0}}, rx_count};
  wire [31:0] read_mux =
    (i_addr == REG_CTRL) ? {31'h00000000, flow_en} :
    (i_addr == REG_RX_DATA) ? ((rx_count != '0) ? {24'h000000, mem_q} : 32'h00000000) :
    (i_addr == REG_STATUS) ? status_word :
    (i_addr == REG_IRQ_STAT) ? {28'h0000000, irq_stat} :
    (i_addr == REG_IRQ_EN) ? {28'h0000000, irq_en} :
    32'h00000000;

  wire next_flow_en = wr_ctrl ? i_wr_data[CTRL_FLOW_BIT] : flow_en;
  wire [IRQ_W-1:0] next_irq_en = wr_en ? i_wr_data[IRQ_W-1:0] : irq_en;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h00000000;
      flow_en <= CTRL_FLOW_RESET;
      irq_en <= IRQ_EN_RESET;
    end else begin
      o_rd_data <= i_rd ? read_mux : 32'h00000000;
      flow_en <= next_flow_en;
      irq_en <= next_irq_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  logic tx_en_int;
  logic [TICK_W-1:0] tx_tick;
  logic [3:0] tx_bit;
  wire [DATA_BITS+1:0] tx_frame = {1'b1, tx_hold, 1'b0};
  wire tx_go = (tx_state == TX_IDLE) && tx_pend && !i_cts_n;
  wire tx_wrap = (tx_state == TX_SHIFT) && (tx_tick == TICK_LAST);
  wire tx_done_ev = tx_wrap && (tx_bit == BIT_STOP);
  wire [3:0] tx_bit_inc = tx_bit + 4'h1;
  wire tx_in_data = (tx_bit != BIT_START) && (tx_bit <= BIT_LAST_DATA);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_state <= TX_IDLE;
      tx_en_int <= 1'b0;
      tx_pend <= 1'b0;
      tx_hold <= '0;
      tx_tick <= '0;
      tx_bit <= BIT_START;
      o_tx <= 1'b1;
      o_tx_en <= 1'b0;
      o_tx_crc_clk <= 1'b0;
      o_tx_crc_data <= 1'b1;
    end else begin
      o_tx_en <= tx_en_int;
      o_tx_crc_data <= o_tx;
      o_tx_crc_clk <= (tx_state == TX_SHIFT) && tx_in_data && (tx_tick == TX_STROBE_TICK);
      if (wr_tx && !tx_pend) begin
        tx_hold <= i_wr_data[DATA_BITS-1:0];
        tx_pend <= 1'b1;
      end
      case (tx_state)
        TX_IDLE: begin
          if (tx_go) begin
            tx_state <= TX_ARM;
            tx_en_int <= 1'b1;
          end
        end
        TX_ARM: begin
          tx_state <= TX_SHIFT;
          tx_pend <= 1'b0;
          tx_tick <= '0;
          tx_bit <= BIT_START;
          o_tx <= tx_frame[0];
        end
        default: begin
          tx_tick <= tx_wrap ? '0 : tx_tick + 1'b1;
          if (tx_done_ev) begin
            tx_state <= TX_IDLE;
            tx_en_int <= 1'b0;
          end else if (tx_wrap) begin
            tx_bit <= tx_bit_inc;
            o_tx <= tx_frame[tx_bit_inc];
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver.

  logic [TICK_W-1:0] rx_tick;
  logic [3:0] rx_bit;
  logic [DATA_BITS-1:0] rx_shift;
  logic rx_strobe_pre;
  logic rx_stop_pre;
  logic rx_last_pre;
  logic rx_last_q;
  logic rx_frame_err;
  wire rx_fall = (rx_state == RX_IDLE) && o_rx_crc_data && !i_rx;
  wire rx_sample = (rx_state == RX_RECV) && (rx_tick == RX_SAMPLE_TICK);
  wire rx_data_bit = (rx_bit != BIT_START) && (rx_bit <= BIT_LAST_DATA);
  wire rx_stop_sample = rx_sample && (rx_bit == BIT_STOP);
  wire rx_push = rx_last_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_state <= RX_IDLE;
      rx_tick <= '0;
      rx_bit <= BIT_START;
      rx_shift <= '0;
      rx_strobe_pre <= 1'b0;
      rx_stop_pre <= 1'b0;
      rx_last_pre <= 1'b0;
      rx_last_q <= 1'b0;
      rx_frame_err <= 1'b0;
      o_rx_crc_data <= 1'b1;
      o_rx_crc_clk <= 1'b0;
      o_rx_done <= 1'b0;
    end else begin
      o_rx_crc_data <= i_rx;
      rx_strobe_pre <= rx_sample && rx_data_bit;
      o_rx_crc_clk <= rx_strobe_pre;
      rx_stop_pre <= rx_stop_sample;
      o_rx_done <= rx_stop_pre;
      rx_frame_err <= rx_stop_sample && !i_rx;
      rx_last_pre <= rx_sample && (rx_bit == BIT_LAST_DATA);
      rx_last_q <= rx_last_pre;
      case (rx_state)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_state <= RX_RECV;
            rx_tick <= '0;
            rx_bit <= BIT_START;
          end
        end
        default: begin
          rx_tick <= (rx_tick == TICK_LAST) ? '0 : rx_tick + 1'b1;
          if (rx_tick == TICK_LAST) begin
            rx_bit <= rx_bit + 4'h1;
          end
          if (rx_sample && rx_data_bit) begin
            rx_shift <= {i_rx, rx_shift[DATA_BITS-1:1]};
          end
          if (rx_stop_sample || (rx_sample && rx_bit == BIT_START && i_rx)) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive store, flow control and interrupts.

  wire rx_full = (rx_count == FULL_COUNT);
  wire push_ok = rx_push && !rx_full;
  wire pop = rd_rx && (rx_count != '0);
  wire [AW-1:0] next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  wire [AW:0] next_count = rx_count + (AW+1)'(push_ok) - (AW+1)'(pop);
  wire next_full = (next_count == FULL_COUNT);

  logic [IRQ_W-1:0] irq_ev;
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_RX_CHAR] = push_ok;
    irq_ev[IRQ_OVERRUN] = rx_push && rx_full;
    irq_ev[IRQ_FRAME] = rx_frame_err;
    irq_ev[IRQ_TX_DONE] = tx_done_ev;
  end
  wire [IRQ_W-1:0] clr_mask = wr_clr ? i_wr_data[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~clr_mask) | irq_ev;

  uart_sb_rx_mem #(
    .WIDTH(DATA_BITS),
    .DEPTH(RX_DEPTH)
  ) u_rx_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(push_ok),
    .i_waddr(wr_ptr),
    .i_wdata(rx_shift),
    .i_raddr(next_rd_ptr),
    .o_rdata(mem_q)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_count <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
      irq_stat <= '0;
      o_irq <= 1'b0;
      o_rts_n <= 1'b0;
    end else begin
      rx_count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= push_ok ? wr_ptr + 1'b1 : wr_ptr;
      irq_stat <= next_irq_stat;
      o_irq <= |(next_irq_stat & next_irq_en);
      o_rts_n <= next_flow_en && next_full;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_tx_go;
    tx_go;
  endsequence
  sequence s_tx_on;
    tx_en_int ##1 o_tx_en && !o_tx;
  endsequence

  chk_tx_enable_path: assert property (s_tx_go |=> s_tx_on)
    else $error("drive enable did not follow clear-to-send");
  chk_tx_start_bit: assert property ($rose(o_tx_en) |-> !o_tx && tx_bit == BIT_START)
    else $error("start bit not driven with drive enable");
  chk_tx_strobe_time: assert property ($rose(o_tx_crc_clk) |-> tx_tick == TICK_W'(TX_STROBE_DLY))
    else $error("transmit strobe not at half bit plus one");
  chk_tx_copy_lag: assert property (o_tx_crc_data == $past(o_tx))
    else $error("transmit copy does not lag serial line");
  chk_rx_start_sample: assert property (rx_fall |-> ##RX_SAMPLE_DLY rx_sample)
    else $error("start bit not sampled on fourth clock");
  chk_rx_strobe_time: assert property (rx_sample && rx_data_bit |-> ##2 o_rx_crc_clk)
    else $error("receive strobe not about mid bit");
  chk_rx_done_stop: assert property (rx_stop_sample |-> ##2 o_rx_done)
    else $error("receive event missed stop bit");
  chk_rx_copy_lag: assert property (o_rx_crc_data == $past(i_rx))
    else $error("receive copy does not lag input");
  chk_rts_on_full: assert property (o_rts_n == (flow_en && rx_full))
    else $error("request-to-send not tied to full store");
  chk_rts_release: assert property ($fell(rx_full) && flow_en |-> !o_rts_n)
    else $error("request-to-send not restored");
  chk_fifo_load: assert property ($rose(o_rx_crc_clk) && rx_bit == BIT_LAST_DATA |-> rx_push)
    else $error("character not stored after last strobe");
  chk_strobe_data: assert property (o_tx_crc_clk |-> tx_in_data && tx_state == TX_SHIFT)
    else $error("transmit strobe outside data bits");
  chk_bit_period: assert property ($changed(tx_bit) && tx_state == TX_SHIFT |-> tx_tick == '0)
    else $error("bit period not one oversampling span");

endmodule
